// ===== logic/usd_uart.sv
// Serial port pins, data path and status flags in one module.
// Assumes the register master issues one-cycle strobes on I_CLOCK and
// that the far serial device runs the same frame format and rate.
//
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module usd_uart
   import usd_pkg::*;
(
   input wire logic I_CLOCK,
   input wire logic I_RST,
   input wire logic [2:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [7:0] O_RDATA,
   input wire logic I_RX_PIN,
   input wire logic I_PIN_SHARE_TX,
   input wire logic I_PIN_SHARE_RX,
   output logic O_TX_PIN,
   output logic O_TX_OE,
   output logic O_RX_SEL,
   output logic O_RX_IRQ
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations.
   logic [7:0] ctrl1, next_ctrl1, ctrl2, next_ctrl2;
   logic [7:0] baud_div, next_baud_div, bcnt, next_bcnt;
   logic tick;
   logic port_en, tx_run, rx_run;
   logic s1, s2, s3, rx_filt, next_rx_filt, rx_line;
   usd_tx_state_t tx_state, next_tx_state;
   logic [3:0] tx_sc, next_tx_sc, tx_bit, next_tx_bit;
   logic [8:0] tx_shift, next_tx_shift;
   logic tx_par, next_tx_par, next_tx_line, tx_load;
   logic [7:0] hold, next_hold;
   logic hold_full, next_hold_full, next_tx_oe, next_rx_sel;
   usd_rx_state_t rx_state, next_rx_state;
   logic [3:0] rx_sc, next_rx_sc, rx_bit, next_rx_bit;
   logic [8:0] rx_shift, next_rx_shift;
   logic [2:0] samp, next_samp, vote;
   logic rx_par, next_rx_par, rx_noise, next_rx_noise;
   logic rx_pbad, next_rx_pbad, maj, decide, push, push_framing_error_flag;
   logic receiver_idle_flag, next_receiver_idle_flag;
   logic [8:0] fifo [0:1];
   logic [8:0] next_fifo [0:1];
   logic [1:0] count, next_count;
   logic rd_ptr, next_rd_ptr;
   logic parity_error_flag, nf, framing_error_flag, overrun_flag, receive_available_flag, transmitter_idle_flag, transmit_empty_flag;
   logic next_parity_error_flag, next_nf, next_framing_error_flag, next_overrun_flag;
   logic next_receive_available_flag, next_transmitter_idle_flag, next_transmit_empty_flag;
   logic seen, seen_receive_available_flag, seen_transmitter_idle_flag, seen_transmit_empty_flag;
   logic next_seen, next_seen_receive_available_flag, next_seen_transmitter_idle_flag, next_seen_transmit_empty_flag;
   logic [7:0] next_rdata, status;
   logic next_irq, data_rd, data_wr, tx_quiet, push_ok;

   assign port_en = ctrl1[C1_PORT_EN];
   assign tx_run = port_en & ctrl2[C2_TX_EN];
   assign rx_run = port_en & ctrl2[C2_RX_EN] & I_PIN_SHARE_RX;
   assign data_rd = I_RD & (I_ADDR == ADDR_DATA);
   assign data_wr = I_WR & (I_ADDR == ADDR_DATA);
   assign status = {parity_error_flag, nf, framing_error_flag, overrun_flag, receiver_idle_flag, receive_available_flag, transmitter_idle_flag, transmit_empty_flag};

   ////////////////////////////////////////////////////////////////////////
   // Baud tick: one tick every divisor plus one clocks, sixteen per bit.
   // The counter restarts whenever the port is off.
   always_comb begin
      next_bcnt = bcnt + 8'h01;
      tick = 1'b0;
      if (!port_en) begin
         next_bcnt = 8'h00;
      end else if (bcnt == baud_div) begin
         next_bcnt = 8'h00;
         tick = 1'b1;
      end
   end

   always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
         bcnt <= 8'h00;
      end else begin
         bcnt <= next_bcnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive pin synchroniser; a level counts once the last two agree.
   always_comb begin
      next_rx_filt = rx_filt;
      if (s2 == s3) begin
         next_rx_filt = s3;
      end
   end

   always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
         s1 <= 1'b1;
         s2 <= 1'b1;
         s3 <= 1'b1;
         rx_filt <= 1'b1;
      end else begin
         s1 <= I_RX_PIN;
         s2 <= s1;
         s3 <= s2;
         rx_filt <= next_rx_filt;
      end
   end

   // A pin not handed to the port reads as an idle line.
   assign rx_line = rx_run ? rx_filt : 1'b1;

   ////////////////////////////////////////////////////////////////////////
   // Transmitter: holding register, shifter and frame sequencer.
   // Buffered data goes out before a requested break.
   always_comb begin
      next_tx_state = tx_state;
      next_tx_sc = tx_sc;
      next_tx_bit = tx_bit;
      next_tx_shift = tx_shift;
      next_tx_par = tx_par;
      next_hold = hold;
      next_hold_full = hold_full;
      tx_load = 1'b0;
      if (tick) begin
         next_tx_sc = tx_sc + 4'h1;
      end
      case (tx_state)
         TX_IDLE: begin
            next_tx_sc = 4'h0;
            if (hold_full) begin
               tx_load = 1'b1;
               next_tx_shift = {ctrl1[C1_TX9], hold};
               next_tx_par = 1'b0;
               next_hold_full = 1'b0;
               next_tx_state = TX_START;
            end else if (ctrl1[C1_BREAK]) begin
               next_tx_bit = 4'h0;
               next_tx_state = TX_BREAK;
            end
         end
         TX_START: begin
            if (tick && tx_sc == OS_LAST) begin
               next_tx_bit = 4'h0;
               next_tx_state = TX_DATA;
            end
         end
         TX_DATA: begin
            if (tick && tx_sc == OS_LAST) begin
               // Least significant bit leaves first.
               next_tx_par = tx_par ^ tx_shift[0];
               next_tx_shift = {1'b0, tx_shift[8:1]};
               next_tx_bit = tx_bit + 4'h1;
               if (tx_bit == (ctrl1[C1_LEN9] ? LAST_BIT_9 : LAST_BIT_8)) begin
                  next_tx_bit = 4'h0;
                  next_tx_state = ctrl1[C1_PAR_EN] ? TX_PAR : TX_STOP;
               end
            end
         end
         TX_PAR: begin
            if (tick && tx_sc == OS_LAST) begin
               next_tx_state = TX_STOP;
            end
         end
         TX_STOP: begin
            if (tick && tx_sc == OS_LAST) begin
               if (ctrl1[C1_STOP2] && tx_bit == 4'h0) begin
                  next_tx_bit = 4'h1;
               end else begin
                  next_tx_state = TX_IDLE;
               end
            end
         end
         TX_BREAK: begin
            // Low for at least thirteen bit times and until released.
            if (tick && tx_sc == OS_LAST && tx_bit != BREAK_BITS) begin
               next_tx_bit = tx_bit + 4'h1;
            end
            if (tx_bit == BREAK_BITS && !ctrl1[C1_BREAK]) begin
               next_tx_state = TX_IDLE;
            end
         end
         default: begin
            next_tx_state = TX_IDLE;
         end
      endcase
      // A write lands after a same-cycle load so no byte is lost.
      if (data_wr) begin
         next_hold = I_WDATA;
         next_hold_full = 1'b1;
      end
      // Clearing either enable aborts the frame and empties the buffer.
      if (!(next_ctrl1[C1_PORT_EN] && next_ctrl2[C2_TX_EN])) begin
         next_tx_state = TX_IDLE;
         next_hold_full = 1'b0;
      end
      case (next_tx_state)
         TX_START: next_tx_line = 1'b0;
         TX_DATA: next_tx_line = next_tx_shift[0];
         TX_PAR: next_tx_line = next_tx_par ^ ctrl1[C1_PAR_ODD];
         TX_BREAK: next_tx_line = 1'b0;
         default: next_tx_line = 1'b1;
      endcase
      next_tx_oe = tx_run & I_PIN_SHARE_TX;
      next_rx_sel = rx_run;
   end

   always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
         tx_state <= TX_IDLE;
         tx_sc <= 4'h0;
         tx_bit <= 4'h0;
         tx_shift <= 9'h000;
         tx_par <= 1'b0;
         hold <= 8'h00;
         hold_full <= 1'b0;
         O_TX_PIN <= 1'b1;
         O_TX_OE <= 1'b0;
         O_RX_SEL <= 1'b0;
      end else begin
         tx_state <= next_tx_state;
         tx_sc <= next_tx_sc;
         tx_bit <= next_tx_bit;
         tx_shift <= next_tx_shift;
         tx_par <= next_tx_par;
         hold <= next_hold;
         hold_full <= next_hold_full;
         O_TX_PIN <= next_tx_line;
         O_TX_OE <= next_tx_oe;
         O_RX_SEL <= next_rx_sel;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receiver: three samples per bit, majority vote, noise on disagreement.
   // Only the first stop bit is checked; a second one is only waited out.
   assign vote = {samp[1:0], rx_line};
   assign maj = (vote[0] & vote[1]) | (vote[0] & vote[2]) |
                (vote[1] & vote[2]);
   assign decide = tick && rx_sc == OS_DECIDE;

   always_comb begin
      next_rx_state = rx_state;
      next_rx_sc = rx_sc;
      next_rx_bit = rx_bit;
      next_rx_shift = rx_shift;
      next_samp = samp;
      next_rx_par = rx_par;
      next_rx_noise = rx_noise;
      next_rx_pbad = rx_pbad;
      push = 1'b0;
      push_framing_error_flag = 1'b0;
      if (tick) begin
         next_rx_sc = rx_sc + 4'h1;
         if (rx_sc >= OS_FIRST_SAMPLE && rx_sc <= OS_DECIDE) begin
            next_samp = vote;
         end
      end
      if (decide && vote != 3'h0 && vote != 3'h7) begin
         next_rx_noise = 1'b1;
      end
      case (rx_state)
         RX_IDLE: begin
            next_rx_sc = 4'h0;
            if (!rx_line) begin
               next_rx_state = RX_START;
               next_rx_noise = 1'b0;
               next_rx_pbad = 1'b0;
               next_rx_par = 1'b0;
            end
         end
         RX_START: begin
            if (decide && maj) begin
               next_rx_state = RX_IDLE; // Glitch, not a start bit.
            end else if (tick && rx_sc == OS_LAST) begin
               next_rx_bit = 4'h0;
               next_rx_state = RX_DATA;
            end
         end
         RX_DATA: begin
            if (decide) begin
               next_rx_shift = {maj, rx_shift[8:1]};
               next_rx_par = rx_par ^ maj;
            end
            if (tick && rx_sc == OS_LAST) begin
               next_rx_bit = rx_bit + 4'h1;
               if (rx_bit == (ctrl1[C1_LEN9] ? LAST_BIT_9 : LAST_BIT_8)) begin
                  next_rx_bit = 4'h0;
                  next_rx_state = ctrl1[C1_PAR_EN] ? RX_PAR : RX_STOP;
               end
            end
         end
         RX_PAR: begin
            if (decide) begin
               next_rx_pbad = (rx_par ^ maj) != ctrl1[C1_PAR_ODD];
            end
            if (tick && rx_sc == OS_LAST) begin
               next_rx_state = RX_STOP;
            end
         end
         RX_STOP: begin
            if (decide && rx_bit == 4'h0) begin
               push = 1'b1;
               push_framing_error_flag = !maj;
            end
            if (tick && rx_sc == OS_LAST) begin
               if (ctrl1[C1_STOP2] && rx_bit == 4'h0) begin
                  next_rx_bit = 4'h1;
               end else begin
                  next_rx_state = RX_IDLE;
               end
            end
         end
         default: begin
            next_rx_state = RX_IDLE;
         end
      endcase
      if (!rx_run) begin
         next_rx_state = RX_IDLE;
      end
      next_receiver_idle_flag = next_rx_state == RX_IDLE;
   end

   always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
         rx_state <= RX_IDLE;
         rx_sc <= 4'h0;
         rx_bit <= 4'h0;
         rx_shift <= 9'h000;
         samp <= 3'h7;
         rx_par <= 1'b0;
         rx_noise <= 1'b0;
         rx_pbad <= 1'b0;
         receiver_idle_flag <= 1'b1;
      end else begin
         rx_state <= next_rx_state;
         rx_sc <= next_rx_sc;
         rx_bit <= next_rx_bit;
         rx_shift <= next_rx_shift;
         samp <= next_samp;
         rx_par <= next_rx_par;
         rx_noise <= next_rx_noise;
         rx_pbad <= next_rx_pbad;
         receiver_idle_flag <= next_receiver_idle_flag;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers, receive buffer and status flags. Clears come first in
   // the process so that a same-cycle hardware set wins, except over a port disable, which comes last.
   assign push_ok = push && !overrun_flag && count != RX_DEPTH;
   assign tx_quiet = tx_state == TX_IDLE && !hold_full &&
                     !ctrl1[C1_BREAK] && !data_wr;

   always_comb begin
      next_ctrl1 = ctrl1;
      next_ctrl2 = ctrl2;
      next_baud_div = baud_div;
      next_fifo[0] = fifo[0];
      next_fifo[1] = fifo[1];
      next_count = count;
      next_rd_ptr = rd_ptr;
      {next_parity_error_flag, next_nf, next_framing_error_flag, next_overrun_flag} = {parity_error_flag, nf, framing_error_flag, overrun_flag};
      next_receive_available_flag = receive_available_flag;
      next_transmit_empty_flag = transmit_empty_flag;
      next_transmitter_idle_flag = transmitter_idle_flag;
      {next_seen, next_seen_receive_available_flag} = {seen, seen_receive_available_flag};
      {next_seen_transmitter_idle_flag, next_seen_transmit_empty_flag} = {seen_transmitter_idle_flag, seen_transmit_empty_flag};
      next_rdata = 8'h00;
      next_irq = 1'b0;
      // Register writes; the receive ninth bit is read-only.
      if (I_WR) begin
         case (I_ADDR)
            ADDR_CTRL1: next_ctrl1 = {I_WDATA[7:2], ctrl1[C1_RX9], I_WDATA[0]};
            ADDR_CTRL2: next_ctrl2 = I_WDATA;
            ADDR_BAUD: next_baud_div = I_WDATA;
            default: next_ctrl1 = ctrl1;
         endcase
      end
      // Reads answer one cycle later; unmapped addresses read zero.
      if (I_RD) begin
         case (I_ADDR)
            ADDR_STATUS: begin
               next_rdata = status;
               next_seen = 1'b1;
               next_seen_receive_available_flag = receive_available_flag;
               next_seen_transmitter_idle_flag = transmitter_idle_flag;
               next_seen_transmit_empty_flag = transmit_empty_flag;
            end
            ADDR_CTRL1: next_rdata = {ctrl1[7:2], fifo[rd_ptr][8], 1'b0};
            ADDR_CTRL2: next_rdata = ctrl2;
            ADDR_DATA: next_rdata = fifo[rd_ptr][7:0];
            ADDR_BAUD: next_rdata = baud_div;
            default: next_rdata = 8'h00;
         endcase
      end
      if (data_rd && count != 2'h0) begin
         next_rd_ptr = ~rd_ptr;
         next_count = count - 2'h1;
      end
      // Status read then data access ends the clearing sequence.
      if ((data_rd || data_wr) && seen) begin
         {next_parity_error_flag, next_nf, next_framing_error_flag, next_overrun_flag} = 4'h0;
         next_seen = 1'b0;
         if (data_rd && seen_receive_available_flag && next_count == 2'h0) begin
            next_receive_available_flag = 1'b0;
         end
         if (data_wr && seen_transmit_empty_flag) begin
            next_transmit_empty_flag = 1'b0;
         end
         if (data_wr && seen_transmitter_idle_flag) begin
            next_transmitter_idle_flag = 1'b0;
         end
      end
      // Character transfer into the two-deep buffer, or an overrun.
      if (push && !overrun_flag) begin
         if (count == RX_DEPTH) begin
            next_overrun_flag = 1'b1;
         end else begin
            next_fifo[rd_ptr ^ count[0]] = ctrl1[C1_LEN9] ? rx_shift :
                                          {1'b0, rx_shift[8:1]};
            next_count = next_count + 2'h1;
            next_receive_available_flag = 1'b1;
            next_irq = ctrl2[C2_RX_IE];
            // The stop bit's own vote is folded in, since the receiver
            // has not yet registered it at the push.
            next_nf = nf | rx_noise | (vote != 3'h0 && vote != 3'h7);
            next_framing_error_flag = framing_error_flag | push_framing_error_flag;
            next_parity_error_flag = parity_error_flag | (ctrl1[C1_PAR_EN] & rx_pbad);
         end
      end
      if (tx_load || !tx_run) begin
         next_transmit_empty_flag = 1'b1;
      end
      // Idle only with nothing held, shifting or breaking.
      next_transmitter_idle_flag = tx_quiet ? 1'b1 : 1'b0;
      if (!next_ctrl1[C1_PORT_EN]) begin
         next_ctrl1[C1_BREAK] = 1'b0;
         next_ctrl2[C2_TX_EN] = 1'b0;
         next_ctrl2[C2_RX_EN] = 1'b0;
         next_count = 2'h0;
         next_receive_available_flag = 1'b0;
         {next_parity_error_flag, next_nf, next_framing_error_flag, next_overrun_flag} = 4'h0;
         next_transmit_empty_flag = 1'b1;
         next_transmitter_idle_flag = 1'b1;
      end
   end

   always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
         ctrl1 <= CTRL_RESET;
         ctrl2 <= CTRL_RESET;
         baud_div <= BAUD_RESET;
         fifo[0] <= 9'h000;
         fifo[1] <= 9'h000;
         count <= 2'h0;
         rd_ptr <= 1'b0;
         {parity_error_flag, nf, framing_error_flag, overrun_flag} <= STATUS_RESET[7:4];
         {receive_available_flag, transmitter_idle_flag, transmit_empty_flag} <= STATUS_RESET[2:0];
         {seen, seen_receive_available_flag, seen_transmitter_idle_flag, seen_transmit_empty_flag} <= 4'h0;
         O_RDATA <= 8'h00;
         O_RX_IRQ <= 1'b0;
      end else begin
         ctrl1 <= next_ctrl1;
         ctrl2 <= next_ctrl2;
         baud_div <= next_baud_div;
         fifo[0] <= next_fifo[0];
         fifo[1] <= next_fifo[1];
         count <= next_count;
         rd_ptr <= next_rd_ptr;
         {parity_error_flag, nf, framing_error_flag, overrun_flag} <= {next_parity_error_flag, next_nf, next_framing_error_flag, next_overrun_flag};
         {receive_available_flag, transmitter_idle_flag, transmit_empty_flag} <= {next_receive_available_flag, next_transmitter_idle_flag, next_transmit_empty_flag};
         {seen, seen_receive_available_flag} <= {next_seen, next_seen_receive_available_flag};
         {seen_transmitter_idle_flag, seen_transmit_empty_flag} <= {next_seen_transmitter_idle_flag, next_seen_transmit_empty_flag};
         O_RDATA <= next_rdata;
         O_RX_IRQ <= next_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks on the behaviour above.
   default clocking @(posedge I_CLOCK); endclocking
   default disable iff (I_RST);

   tx_oe_gate_a: assert property (
      !(tx_run && I_PIN_SHARE_TX) |=> !O_TX_OE)
      else $error("transmit pin driven while not selected");
   rx_gate_a: assert property (
      !rx_run |=> rx_state == RX_IDLE && !O_RX_SEL)
      else $error("receiver active while pin not selected");
   tx_start_bit_a: assert property (
      tx_load && tx_run |=> tx_state == TX_START && !O_TX_PIN)
      else $error("start bit missing after load");
   rx_avail_set_a: assert property (
      push_ok && port_en |=> receive_available_flag && count != 2'h0)
      else $error("accepted character not flagged");
   overrun_block_a: assert property (
      overrun_flag && push && !data_rd && port_en |=> $stable(count))
      else $error("transfer while overrun set");
   noise_with_avail_a: assert property (
      $rose(nf) |-> $past(push_ok) && receive_available_flag)
      else $error("noise flag set without a transfer");
   err_clear_seq_a: assert property (
      seen && data_rd && !push |=> !overrun_flag && !framing_error_flag && !parity_error_flag && !nf)
      else $error("error flags survive clearing sequence");
   idle_pin_high_a: assert property (
      transmitter_idle_flag |-> O_TX_PIN)
      else $error("transmit pin low while idle");
   rx_busy_start_a: assert property (
      $fell(receiver_idle_flag) |-> !$past(rx_line))
      else $error("receiver left idle without start level");
   disable_reset_a: assert property (
      !port_en && !I_WR |=> count == 2'h0 && transmit_empty_flag && transmitter_idle_flag && receiver_idle_flag)
      else $error("port disable did not reset state");

endmodule

`default_nettype wire

// ===== logic/usd_pkg.sv
// Shared constants for the serial port data path and status block.
// Assumes a single system clock and a plain byte-wide register port.
package usd_pkg;

   // Register word addresses on the plain register port.
   localparam logic [2:0] ADDR_STATUS = 3'h0;
   localparam logic [2:0] ADDR_CTRL1 = 3'h1;
   localparam logic [2:0] ADDR_CTRL2 = 3'h2;
   localparam logic [2:0] ADDR_DATA = 3'h3;
   localparam logic [2:0] ADDR_BAUD = 3'h4;

   // Control register one field positions.
   localparam int C1_PORT_EN = 7;
   localparam int C1_LEN9 = 6;
   localparam int C1_PAR_EN = 5;
   localparam int C1_PAR_ODD = 4;
   localparam int C1_STOP2 = 3;
   localparam int C1_BREAK = 2;
   localparam int C1_RX9 = 1;
   localparam int C1_TX9 = 0;

   // Control register two field positions.
   localparam int C2_TX_EN = 7;
   localparam int C2_RX_EN = 6;
   localparam int C2_RX_IE = 2;

   // Reset values.
   localparam logic [7:0] STATUS_RESET = 8'h0b;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] BAUD_RESET = 8'h00;

   // Oversampling: sixteen baud ticks per bit, samples at 7, 8 and 9.
   localparam logic [3:0] OS_LAST = 4'hf;
   localparam logic [3:0] OS_FIRST_SAMPLE = 4'h7;
   localparam logic [3:0] OS_DECIDE = 4'h9;

   // Bit counts and receive buffer depth.
   localparam logic [3:0] LAST_BIT_8 = 4'h7;
   localparam logic [3:0] LAST_BIT_9 = 4'h8;
   localparam logic [3:0] BREAK_BITS = 4'hd;
   localparam logic [1:0] RX_DEPTH = 2'h2;

   typedef enum logic [2:0] {
      TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_BREAK
   } usd_tx_state_t;

   typedef enum logic [2:0] {
      RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
   } usd_rx_state_t;

endpackage

// ===== verification/usd_far_end.sv
// Far serial device: sends frames on the receive line, collects
// frames seen on the transmit wire. Assumes baud divisor 0.
`timescale 1ns/1ps
`default_nettype none
module usd_far_end (
   input wire logic i_clk,
   input wire logic i_line,
   output logic o_line
);
   int got[$];
   // The line idles high between frames.
   initial o_line = 1'b1;
   // Start, eight bits LSB first, stop; bad pulls the stop low.
   task automatic send(input logic [7:0] b, input logic bad);
      send_raw({3'h7, ~bad, b, 1'b0}, 10, -1);
   endtask
   // Sends n bits of f LSB first, sixteen clocks each. Bit g carries a
   // two-clock glitch late in the bit, so that only the last of the
   // three receiver samples sees it and the vote still holds.
   task automatic send_raw(input logic [12:0] f, input int n,
                           input int g);
      for (int i = 0; i < n; i++) begin
         @(posedge i_clk) o_line <= f[i];
         repeat (10) @(posedge i_clk);
         if (i == g) o_line <= ~f[i];
         repeat (2) @(posedge i_clk);
         o_line <= f[i];
         repeat (3) @(posedge i_clk);
      end
      @(posedge i_clk) o_line <= 1'b1;
   endtask
   // Samples mid-bit, phased from the start edge.
   always begin
      logic [7:0] b;
      @(negedge i_line);
      repeat (24) @(posedge i_clk);
      for (int i = 0; i < 8; i++) begin
         b[i] = i_line;
         repeat (16) @(posedge i_clk);
      end
      got.push_back(int'(b));
   end
endmodule
`default_nettype wire

// ===== verification/uart_pins_data_path_status_bench.sv
// Bench for the serial port: register tasks, far device, verdict.
// Assumes a pull-up on the transmit wire while the port lets it go.
`timescale 1ns/1ps
`default_nettype none
module uart_pins_data_path_status_bench;
   import usd_pkg::*;
   logic I_CLOCK = 1'b0;
   logic I_RST = 1'b1;
   logic I_WR = 1'b0;
   logic I_RD = 1'b0;
   logic share = 1'b1;
   logic [2:0] I_ADDR = 3'h0;
   logic [7:0] I_WDATA = 8'h00;
   logic [7:0] O_RDATA, r;
   logic O_TX_PIN, O_TX_OE, O_RX_SEL, O_RX_IRQ, rx_line;
   int n_fail = 0, compares = 0, seed = 56769, irqs = 0;
   int exp_q[$];
   wire logic tx_wire = O_TX_OE ? O_TX_PIN : 1'b1;
   usd_uart dut (.I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_ADDR(I_ADDR),
      .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
      .I_RX_PIN(rx_line), .I_PIN_SHARE_TX(share),
      .I_PIN_SHARE_RX(share), .O_TX_PIN(O_TX_PIN), .O_TX_OE(O_TX_OE),
      .O_RX_SEL(O_RX_SEL), .O_RX_IRQ(O_RX_IRQ));
   usd_far_end far (.i_clk(I_CLOCK), .i_line(tx_wire), .o_line(rx_line));
   // Clock at 40 MHz and a count of receive interrupt pulses.
   always #12.5 I_CLOCK = ~I_CLOCK;
   always @(posedge I_CLOCK) if (O_RX_IRQ === 1'b1) irqs++;
   ////////////////////////////////////////////////////////////////////
   // Comparison and register bus tasks.
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %h not %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge I_CLOCK);
      I_WR <= 1'b1;
      I_ADDR <= a;
      I_WDATA <= d;
      @(posedge I_CLOCK);
      I_WR <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe.
   task automatic rd(input logic [2:0] a);
      @(posedge I_CLOCK);
      I_RD <= 1'b1;
      I_ADDR <= a;
      @(posedge I_CLOCK);
      I_RD <= 1'b0;
      #1 r = O_RDATA;
   endtask
   task automatic report_and_stop;
      $display("compares %0d, n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   // Main sequence: reset, pins, transmit, overrun, framing, disable.
   initial begin
      logic [7:0] b;
      repeat (5) @(posedge I_CLOCK);
      I_RST <= 1'b0;
      rd(ADDR_STATUS); chk(r, STATUS_RESET);
      rd(3'h5); chk(r, 8'h00);
      // The enables only stick once the port itself is on.
      wr(ADDR_BAUD, 8'h00);
      wr(ADDR_CTRL1, 8'h80);
      wr(ADDR_CTRL2, 8'hc4);
      repeat (3) @(posedge I_CLOCK);
      chk({6'h00, O_TX_OE, O_RX_SEL}, 8'h03);
      share <= 1'b0;
      repeat (3) @(posedge I_CLOCK);
      chk({6'h00, O_TX_OE, O_RX_SEL}, 8'h00);
      share <= 1'b1;
      b = 8'($random(seed));
      rd(ADDR_STATUS); chk(r, 8'h0b);
      wr(ADDR_DATA, b);
      for (int i = 0; i < 400 && far.got.size() == 0; i++)
         @(posedge I_CLOCK);
      if (far.got.size() == 0) begin
         n_fail++;
         $display("wrong value at %0t: no frame on the wire", $time);
         report_and_stop();
      end
      chk(8'(far.got.pop_front()), b);
      repeat (16) @(posedge I_CLOCK);
      rd(ADDR_STATUS); chk(r, 8'h0b);
      // Four frames unread: the third overruns, the fourth is blocked.
      for (int i = 0; i < 4; i++) begin
         b = 8'($random(seed));
         exp_q.push_back(int'(b));
         far.send(b, 1'b0);
      end
      repeat (20) @(posedge I_CLOCK);
      rd(ADDR_STATUS); chk(r, 8'h1f);
      rd(ADDR_DATA); chk(r, 8'(exp_q[0]));
      rd(ADDR_STATUS); chk(r, 8'h0f);
      rd(ADDR_DATA); chk(r, 8'(exp_q[1]));
      rd(ADDR_STATUS); chk(r, 8'h0b);
      chk(8'(irqs), 8'h02);
      // A low stop bit; receiver idle is masked, the low tail may start.
      far.send(8'ha5, 1'b1);
      repeat (20) @(posedge I_CLOCK);
      rd(ADDR_STATUS); chk(r & 8'hf7, 8'h27);
      rd(ADDR_DATA); chk(r, 8'ha5);
      // Nine bits, wrong even parity, two stop bits, a glitch on data bit 3.
      wr(ADDR_CTRL1, 8'he8);
      b = 8'($random(seed));
      far.send_raw({2'h3, ^b, 1'b1, b, 1'b0}, 13, 4);
      repeat (20) @(posedge I_CLOCK);
      rd(ADDR_STATUS); chk(r & 8'hf7, 8'hc7);
      rd(ADDR_CTRL1); chk(r, 8'hea);
      rd(ADDR_DATA); chk(r, b);
      repeat (200) @(posedge I_CLOCK);
      wr(ADDR_CTRL1, 8'h00);
      repeat (3) @(posedge I_CLOCK);
      rd(ADDR_STATUS); chk(r, 8'h0b);
      chk({6'h00, O_TX_OE, O_RX_SEL}, 8'h00);
      report_and_stop();
   end
endmodule
`default_nettype wire
